// File: verilog/gptmr_defines.vh
`ifndef GPTMR_DEFINES_VH
`define GPTMR_DEFINES_VH
// Register byte offsets
`define GPTMR_OFF_CTRL      4'h0
`define GPTMR_OFF_PERIOD    4'h4
`define GPTMR_OFF_COUNT     4'h8
`define GPTMR_OFF_STATUS    4'hC
// Timer control register fields
`define GPTMR_CTL_ON        15
`define GPTMR_CTL_IDLESTOP  13
`define GPTMR_CTL_GATE      6
`define GPTMR_CTL_PS_HI     5
`define GPTMR_CTL_PS_LO     4
`define GPTMR_CTL_SYNC      2
`define GPTMR_CTL_EXTCLK    1
`define GPTMR_CTL_MASK      16'hA076
// Reset values
`define GPTMR_RST_CTRL      16'h0000
`define GPTMR_RST_PERIOD    16'hFFFF
// Prescale shift per select code: 1, 8, 64, 256
`define GPTMR_PS_LOG1       4'h0
`define GPTMR_PS_LOG8       4'h3
`define GPTMR_PS_LOG64      4'h6
`define GPTMR_PS_LOG256     4'h8
// AXI responses
`define GPTMR_RESP_OKAY     2'b00
`define GPTMR_RESP_SLVERR   2'b10
`endif

// File: verilog/gptmr_prescaler.v
`timescale 1ns/1ps
`include "gptmr_defines.vh"
module gptmr_prescaler #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Control
  input  wire       clear,
  input  wire [1:0] select,
  input  wire       tick,
  // Output
  output reg        pulse
);
  reg  [WIDTH-1:0] div;
  reg  [3:0]       shiftLog;
  wire [WIDTH-1:0] limit;

  always @* begin
    case (select)
      2'b00:   shiftLog = `GPTMR_PS_LOG1;
      2'b01:   shiftLog = `GPTMR_PS_LOG8;
      2'b10:   shiftLog = `GPTMR_PS_LOG64;
      default: shiftLog = `GPTMR_PS_LOG256;
    endcase
  end

  assign limit = ({{(WIDTH-1){1'b0}}, 1'b1} << shiftLog) - {{(WIDTH-1){1'b0}}, 1'b1};

  always @(posedge sys_clk) begin
    if (!rst_n || clear) begin
      div   <= {WIDTH{1'b0}};
      pulse <= 1'b0;
    end else begin
      pulse <= 1'b0;
      if (tick) begin
        if (div >= limit) begin
          div   <= {WIDTH{1'b0}};
          pulse <= 1'b1;
        end else begin
          div <= div + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // gptmr_prescaler

// File: verilog/gptmr_timer.v
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "gptmr_defines.vh"
// Overview of operation
// - Timer mode counts each instruction cycle to period, then clears and continues.
// - In idle, timer and synchronous counter halt when idle stop select is one.
// - With idle stop select one, counting resumes from held count after idle.
// - Synchronous counter synchronizes external clock, counts each synchronized rising edge.
// - Both external counter modes count to period, clear to zero, continue.
// - Asynchronous counter counts every external rising edge through the same internal synchronizer as synchronous mode.
// - Asynchronous counter stops during idle when idle stop select is one.
// - Interrupt on period match, or on gate falling edge in gated operation.
module gptmr_timer (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // Core signals
  input  wire        instrTick,
  input  wire        cpuIdle,
  // External pins
  input  wire        extClk,
  input  wire        gateIn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt
  output reg         irq
);
  reg  [15:0] timerControl;
  reg  [15:0] periodRegister;
  reg  [15:0] count;
  reg         matchFlag;
  reg         gateFlag;
  reg  [2:0]  extSync;
  reg  [1:0]  gateSync;
  reg         gatePrev;
  reg  [3:0]  awAddr;
  reg  [31:0] wData;
  reg  [3:0]  wStrb;
  reg         awHeld;
  reg         wHeld;

  wire [15:0] ctlMask  = `GPTMR_CTL_MASK;
  wire        enabled  = timerControl[`GPTMR_CTL_ON];
  wire        idleStop = timerControl[`GPTMR_CTL_IDLESTOP];
  wire        useExt   = timerControl[`GPTMR_CTL_EXTCLK];
  wire        syncMode = timerControl[`GPTMR_CTL_SYNC];
  wire        gated    = timerControl[`GPTMR_CTL_GATE] && !useExt;
  wire        extRise  = extSync[1] && !extSync[2];
  wire        gateFall = gatePrev && !gateSync[1];
  wire        halted   = cpuIdle && idleStop;
  wire        rawTick  = useExt ? extRise : (instrTick && (!gated || gateSync[1]));
  wire        scaled;
  wire        doWrite  = awHeld && wHeld && !s_axi_bvalid;
  wire        wrCtrl   = doWrite && awAddr == `GPTMR_OFF_CTRL;
  wire        wrPeriod = doWrite && awAddr == `GPTMR_OFF_PERIOD;
  wire        wrCount  = doWrite && awAddr == `GPTMR_OFF_COUNT;
  wire        wrStatus = doWrite && awAddr == `GPTMR_OFF_STATUS;
  wire        matchHit = enabled && !halted && scaled && count == periodRegister;
  wire        gateHit  = enabled && gated && gateFall;

  // Prescaler also frozen by idle so resumption continues from held state
  gptmr_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (!enabled),
    .select  (timerControl[`GPTMR_CTL_PS_HI:`GPTMR_CTL_PS_LO]),
    .tick    (rawTick && enabled && !halted),
    .pulse   (scaled)
  );

  // Pins pass two flops first; async mode shares this path, being single-clock
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      extSync  <= 3'b000;
      gateSync <= 2'b00;
      gatePrev <= 1'b0;
    end else begin
      extSync  <= {extSync[1:0], extClk};
      gateSync <= {gateSync[0], gateIn};
      gatePrev <= gateSync[1];
    end
  end

  // Pulse lags prescaler tick by one cycle; halt checked on the pulse
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= 16'h0000;
    end else if (wrCount && wStrb[1:0] == 2'b11) begin
      count <= wData[15:0];
    end else if (enabled && !halted && scaled) begin
      if (count == periodRegister)
        count <= 16'h0000;
      else
        count <= count + 16'h0001;
    end
  end

  // Set wins over clear; write one clears
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      matchFlag <= 1'b0;
      gateFlag  <= 1'b0;
      irq       <= 1'b0;
    end else begin
      matchFlag <= matchHit | (matchFlag & ~(wrStatus & wStrb[0] & wData[0]));
      gateFlag  <= gateHit | (gateFlag & ~(wrStatus & wStrb[0] & wData[1]));
      irq       <= matchHit | gateHit | matchFlag | gateFlag;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      timerControl   <= `GPTMR_RST_CTRL;
      periodRegister <= `GPTMR_RST_PERIOD;
    end else begin
      if (wrCtrl) begin
        if (wStrb[0])
          timerControl[7:0] <= wData[7:0] & ctlMask[7:0];
        if (wStrb[1])
          timerControl[15:8] <= wData[15:8] & ctlMask[15:8];
      end
      if (wrPeriod) begin
        if (wStrb[0])
          periodRegister[7:0] <= wData[7:0];
        if (wStrb[1])
          periodRegister[15:8] <= wData[15:8];
      end
    end
  end

  // Write channel: address and data taken in either order
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 4'h0;
      wData         <= 32'h00000000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPTMR_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `GPTMR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; every word-aligned offset in the 16-byte window is mapped
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GPTMR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `GPTMR_RESP_OKAY;
        case ({s_axi_araddr[3:2], 2'b00})
          `GPTMR_OFF_CTRL:   s_axi_rdata <= {16'h0000, timerControl};
          `GPTMR_OFF_PERIOD: s_axi_rdata <= {16'h0000, periodRegister};
          `GPTMR_OFF_COUNT:  s_axi_rdata <= {16'h0000, count};
          default:           s_axi_rdata <= {30'h00000000, gateFlag, matchFlag};
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // gptmr_timer

// File: verification/gptmr_timer_assertions.sv
`timescale 1ns/1ps
module gptmr_timer_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Interrupt
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  AST_ARREADY_PULSE: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  AST_RESP_OKAY: assert property (s_axi_bvalid || s_axi_rvalid |-> s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0)
    else $error("bad response");
  AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("irq fell without a write");
endmodule // gptmr_timer_chk
bind gptmr_timer gptmr_timer_chk u_chk (.*);

// File: verification/tb_gptmr_timer.sv
`timescale 1ns/1ps
`include "gptmr_defines.vh"
module tb_gptmr_timer;
  logic sys_clk = 0, rst_n = 0, instrTick = 0, cpuIdle = 0, extClk = 0, gateIn = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int errors = 0, n_tests = 0, cyc = 0, p, n;
  logic [31:0] expQ[$];
  gptmr_timer dut (.*);
  always #2 sys_clk = ~sys_clk;
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task results();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    expQ.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task ticks(int k);
    repeat (k) begin
      @(posedge sys_clk) instrTick <= 1;
      @(posedge sys_clk) instrTick <= 0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  task ext(int k);
    repeat (k) begin
      repeat (3) @(posedge sys_clk);
      extClk <= 1;
      repeat (3) @(posedge sys_clk);
      extClk <= 0;
    end
    repeat (6) @(posedge sys_clk);
  endtask
  // Reads answered in order, so the oldest note matches
  always @(posedge sys_clk) begin
    if (rst_n && s_axi_rvalid && s_axi_rready) chk("rdata", expQ.pop_front(), s_axi_rdata);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h30b3f861));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1;
    rd(`GPTMR_OFF_CTRL, 0);
    rd(`GPTMR_OFF_PERIOD, 32'h0000FFFF);
    p = 5 + $urandom % 6;
    n = p + 1 + $urandom % 10;
    wr(`GPTMR_OFF_PERIOD, p);
    wr(`GPTMR_OFF_COUNT, 0);
    wr(`GPTMR_OFF_CTRL, 32'h8000);
    ticks(n);
    rd(`GPTMR_OFF_COUNT, n % (p + 1));
    rd(`GPTMR_OFF_STATUS, 1);
    chk("irq", 1, irq);
    wr(`GPTMR_OFF_STATUS, 3);
    rd(`GPTMR_OFF_STATUS, 0);
    wr(`GPTMR_OFF_COUNT, 0);
    wr(`GPTMR_OFF_CTRL, 32'hA000);
    cpuIdle <= 1;
    ticks(5);
    rd(`GPTMR_OFF_COUNT, 0);
    cpuIdle <= 0;
    ticks(2);
    rd(`GPTMR_OFF_COUNT, 2);
    wr(`GPTMR_OFF_CTRL, 32'h8000);
    cpuIdle <= 1;
    ticks(2);
    rd(`GPTMR_OFF_COUNT, 4);
    cpuIdle <= 0;
    // Asynchronous then synchronous external counting
    for (int m = 0; m < 2; m++) begin
      n = $urandom % 12;
      wr(`GPTMR_OFF_COUNT, 0);
      wr(`GPTMR_OFF_CTRL, 32'h8002 | (m << 2));
      ext(n);
      rd(`GPTMR_OFF_COUNT, n % (p + 1));
      wr(`GPTMR_OFF_CTRL, 32'hA002 | (m << 2));
      wr(`GPTMR_OFF_COUNT, 0);
      cpuIdle <= 1;
      ext(3);
      rd(`GPTMR_OFF_COUNT, 0);
      cpuIdle <= 0;
    end
    wr(`GPTMR_OFF_PERIOD, 32'hFFFF);
    // Prescale codes 1 to 3: two full divisions give a count of two
    for (int s = 1; s < 4; s++) begin
      wr(`GPTMR_OFF_CTRL, 0);
      wr(`GPTMR_OFF_COUNT, 0);
      wr(`GPTMR_OFF_CTRL, 32'h8000 | (s << 4));
      n = (s == 3) ? 512 : (2 << (3 * s));
      ticks(n);
      rd(`GPTMR_OFF_COUNT, 2);
    end
    wr(`GPTMR_OFF_STATUS, 3);
    wr(`GPTMR_OFF_CTRL, 32'h8040);
    instrTick <= 1;
    gateIn <= 1;
    repeat (10) @(posedge sys_clk);
    gateIn <= 0;
    repeat (6) @(posedge sys_clk);
    instrTick <= 0;
    rd(`GPTMR_OFF_STATUS, 2);
    // Ten synchronised gate-high cycles counted on top of two
    rd(`GPTMR_OFF_COUNT, 12);
    repeat (5) @(posedge sys_clk);
    results();
  end
endmodule // tb_gptmr_timer
